// ==== design/cecr_top.sv ====
// Charger emulation configuration register bank with its timers.
// Assumes a plain register port, synchronous inputs and one 250 MHz clock.
//
// Operation
// - Flag emulation success when VBUS current exceeds the programmed threshold.
// - Threshold uses bits 3..0, weights 9.76 to 78.1 mA, resets to 01h.
// - Threshold returns to its default while the device sleeps.
// - Over-temperature starts cool-down timer; reduced limit held until it expires.
// - Cool-down field bits 4..3 decode 200, 400, 800, 1600 ms.
// - Recharge delay starts after bypass re-enable; attach ignored until expiry.
// - Recharge field bits 2..0 decode 200..1400 ms steps, 111 gives 2000 ms.
// - Above 800 ms, present device, switch off: report removal then attach.
// - Timer, enable and timeout registers keep contents through sleep.
// - Dedicated disable bit skips that profile unless dedicated mode is active.
// - Legacy enable bits 6..0 exclude legacy profiles 7..1 when set.
// - Each profile's two-bit timeout applies: 0.8, 1.6, 6.4, 12.8 s.
// - Global timeout disable suppresses all per-profile timeouts.
// - Dedicated timeout in bits 5..4, resets to 01, register 10h.
// - Dedicated timeout bits 3..2 ignore writes; bits 1..0 read zero.
// - Legacy timeouts: profiles 1..4 in first register, 5..7 in second.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module cecr_top
  import cecr_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = CECR_TICK_CYCLES // Cycles per millisecond
) (
  input wire logic mclk, // System clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic [7:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr_stb, // Write strobe
  input wire logic rd_stb, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after read strobe
  input wire logic sleep_active, // Device in sleep state
  input wire logic [7:0] vbus_current, // Measured VBUS current, 9.76 mA units
  input wire logic temp_over, // Die above regulation threshold
  input wire logic bypass_reenabled, // Pulse: VBUS discharged, bypass back on
  input wire logic device_present, // Portable device attached
  input wire logic power_switch_enable, // Power switch enable level
  input wire logic attach_detect, // Raw attach detection level
  input wire logic dedicated_mode_active, // Mode selection chose dedicated mode
  input wire logic global_timeout_disable, // Disable all profile timeouts
  input wire logic profile_start, // Pulse: a profile starts in the cycle
  input wire logic [2:0] profile_index, // 0 dedicated, 1..7 legacy profile
  output logic emulation_success, // Current above threshold
  output logic cooldown_active, // Hold reduced current limit
  output logic recharge_active, // Recharge delay running
  output logic attach_event, // Pulse: attach recognised
  output logic removal_event, // Pulse: removal reported
  output logic dedicated_profile_skip, // Skip dedicated profile in cycle
  output logic [6:0] legacy_profile_enable, // Legacy profiles 7..1 enabled
  output logic emulation_timing, // Profile timeout running
  output logic profile_timeout // Pulse: profile timed out
);

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [7:0] thresh_q;
  logic [7:0] timers_q;
  logic [7:0] std_en_q;
  logic [7:0] leg_en_q;
  logic [7:0] std_to_q;
  logic [7:0] leg_to1_q;
  logic [7:0] leg_to2_q;
  logic [7:0] rdata_q;
  cecr_cfg_t cfg;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = wr_stb && (a == off);
  endfunction

  // Threshold is not retained in sleep
  always_ff @(posedge mclk) begin
    if (!resetn || sleep_active) begin
      thresh_q <= CECR_RST_THRESH;
    end else if (hit(addr, CECR_ADDR_THRESH)) begin
      thresh_q <= wdata & CECR_MASK_THRESH;
    end
  end

  // Remaining registers are retained in sleep
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      timers_q <= CECR_RST_TIMERS;
      std_en_q <= CECR_RST_STD_EN;
      leg_en_q <= CECR_RST_LEG_EN;
      std_to_q <= CECR_RST_STD_TO;
      leg_to1_q <= CECR_RST_LEG_TO1;
      leg_to2_q <= CECR_RST_LEG_TO2;
    end else begin
      if (hit(addr, CECR_ADDR_TIMERS)) begin
        timers_q <= wdata & CECR_MASK_TIMERS;
      end
      if (hit(addr, CECR_ADDR_STD_EN)) begin
        std_en_q <= (wdata & CECR_MASK_STD_EN) | CECR_FIXED_STD_EN;
      end
      if (hit(addr, CECR_ADDR_LEG_EN)) begin
        leg_en_q <= wdata & CECR_MASK_LEG_EN;
      end
      if (hit(addr, CECR_ADDR_STD_TO)) begin
        std_to_q <= wdata & CECR_MASK_STD_TO;
      end
      if (hit(addr, CECR_ADDR_LEG_TO1)) begin
        leg_to1_q <= wdata & CECR_MASK_LEG_TO1;
      end
      if (hit(addr, CECR_ADDR_LEG_TO2)) begin
        leg_to2_q <= wdata & CECR_MASK_LEG_TO2;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  function automatic logic [7:0] read_mux(input logic [7:0] a);
    unique case (a)
      CECR_ADDR_THRESH: read_mux = thresh_q;
      CECR_ADDR_TIMERS: read_mux = timers_q;
      CECR_ADDR_STD_EN: read_mux = std_en_q;
      CECR_ADDR_LEG_EN: read_mux = leg_en_q;
      CECR_ADDR_STD_TO: read_mux = std_to_q;
      CECR_ADDR_LEG_TO1: read_mux = leg_to1_q;
      CECR_ADDR_LEG_TO2: read_mux = leg_to2_q;
      default: read_mux = CECR_READ_NONE;
    endcase
  endfunction

  // Data stand only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdata_q <= CECR_READ_NONE;
    end else if (rd_stb) begin
      rdata_q <= read_mux(addr);
    end else begin
      rdata_q <= CECR_READ_NONE;
    end
  end

  // ----------------------------------------------------------------------
  // Field view
  // ----------------------------------------------------------------------
  always_comb begin
    cfg.thresh = thresh_q[3:0];
    cfg.cool_sel = timers_q[4:3];
    cfg.rech_sel = timers_q[2:0];
    cfg.ded_dis = std_en_q[4];
    cfg.leg_dis = leg_en_q[6:0];
    cfg.ded_to = std_to_q[5:4];
    cfg.leg_to[0] = leg_to1_q[7:6];
    cfg.leg_to[1] = leg_to1_q[5:4];
    cfg.leg_to[2] = leg_to1_q[3:2];
    cfg.leg_to[3] = leg_to1_q[1:0];
    cfg.leg_to[4] = leg_to2_q[5:4];
    cfg.leg_to[5] = leg_to2_q[3:2];
    cfg.leg_to[6] = leg_to2_q[1:0];
  end

  // Timeout code for the running profile
  function automatic logic [1:0] profile_code(input cecr_cfg_t c, input logic [2:0] idx);
    if (idx == CECR_PROFILE_DEDICATED) begin
      profile_code = c.ded_to;
    end else begin
      profile_code = c.leg_to[3'(idx - 3'h1)];
    end
  endfunction

  // ----------------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------------
  logic [31:0] presc_q;
  logic tick_q;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      presc_q <= '0;
      tick_q <= 1'b0;
    end else if (presc_q >= 32'(TICK_CYCLES - 1)) begin
      presc_q <= '0;
      tick_q <= 1'b1;
    end else begin
      presc_q <= presc_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Profile enables and success detection
  // ----------------------------------------------------------------------
  logic success_q;
  logic skip_q;
  logic [6:0] leg_en_out_q;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      success_q <= 1'b0;
      skip_q <= 1'b0;
      leg_en_out_q <= '0;
    end else begin
      success_q <= vbus_current > {4'h0, cfg.thresh};
      skip_q <= cfg.ded_dis && !dedicated_mode_active;
      leg_en_out_q <= ~cfg.leg_dis;
    end
  end

  // ----------------------------------------------------------------------
  // Thermal cool-down
  // ----------------------------------------------------------------------
  logic temp_prev_q;
  logic cool_start;
  logic cool_run;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      temp_prev_q <= 1'b0;
    end else begin
      temp_prev_q <= temp_over;
    end
  end

  assign cool_start = temp_over && !temp_prev_q;

  cecr_timer u_cool (
    .mclk(mclk),
    .resetn(resetn),
    .tick(tick_q),
    .start(cool_start),
    .stop(1'b0),
    .load_ms(cecr_cool_ms(cfg.cool_sel)),
    .running(cool_run),
    .expired()
  );

  // ----------------------------------------------------------------------
  // Recharge delay and attach reporting
  // ----------------------------------------------------------------------
  logic rech_run;
  logic rech_done;
  logic attach_prev_q;
  logic attach_pend_q;
  logic attach_q;
  logic removal_q;
  cecr_att_t att_q;
  logic long_redo;

  cecr_timer u_rech (
    .mclk(mclk),
    .resetn(resetn),
    .tick(tick_q),
    .start(bypass_reenabled),
    .stop(1'b0),
    .load_ms(cecr_rech_ms(cfg.rech_sel)),
    .running(rech_run),
    .expired(rech_done)
  );

  // Long delay with a device present and the switch off reports removal then attach
  assign long_redo = rech_done && cfg.rech_sel > CECR_RECH_SEL_800 && device_present
                     && !power_switch_enable;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      attach_prev_q <= 1'b0;
    end else begin
      attach_prev_q <= attach_detect;
    end
  end

  // Attach seen during the delay is held until it ends
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      attach_pend_q <= 1'b0;
    end else if (attach_detect && !attach_prev_q && (rech_run || bypass_reenabled)) begin
      attach_pend_q <= 1'b1;
    end else if (rech_done || bypass_reenabled) begin
      attach_pend_q <= 1'b0;
    end
  end

  // Removal then fresh attach after a long delay
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      att_q <= CECR_ATT_IDLE;
    end else begin
      unique case (att_q)
        CECR_ATT_IDLE: begin
          if (long_redo) begin
            att_q <= CECR_ATT_REMOVE;
          end
        end
        CECR_ATT_REMOVE: begin
          att_q <= CECR_ATT_REATTACH;
        end
        CECR_ATT_REATTACH: begin
          att_q <= CECR_ATT_IDLE;
        end
        default: begin
          att_q <= CECR_ATT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      removal_q <= 1'b0;
      attach_q <= 1'b0;
    end else begin
      removal_q <= (att_q == CECR_ATT_REMOVE);
      attach_q <= (att_q == CECR_ATT_REATTACH)
                  || (rech_done && attach_pend_q && !long_redo && att_q == CECR_ATT_IDLE)
                  || (attach_detect && !attach_prev_q && !rech_run && !bypass_reenabled);
    end
  end

  // ----------------------------------------------------------------------
  // Per-profile emulation timeout
  // ----------------------------------------------------------------------
  logic emu_run;
  logic emu_done;
  logic emu_start;

  assign emu_start = profile_start && !global_timeout_disable;

  cecr_timer u_emu (
    .mclk(mclk),
    .resetn(resetn),
    .tick(tick_q),
    .start(emu_start),
    .stop(global_timeout_disable),
    .load_ms(cecr_emu_ms(profile_code(cfg, profile_index))),
    .running(emu_run),
    .expired(emu_done)
  );

  // ----------------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------------
  logic cool_out_q;
  logic rech_out_q;
  logic emu_run_q;
  logic emu_done_q;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cool_out_q <= 1'b0;
      rech_out_q <= 1'b0;
      emu_run_q <= 1'b0;
      emu_done_q <= 1'b0;
    end else begin
      cool_out_q <= cool_run;
      rech_out_q <= rech_run;
      emu_run_q <= emu_run && !global_timeout_disable;
      emu_done_q <= emu_done && !global_timeout_disable;
    end
  end

  assign rdata = rdata_q;
  assign emulation_success = success_q;
  assign cooldown_active = cool_out_q;
  assign recharge_active = rech_out_q;
  assign attach_event = attach_q;
  assign removal_event = removal_q;
  assign dedicated_profile_skip = skip_q;
  assign legacy_profile_enable = leg_en_out_q;
  assign emulation_timing = emu_run_q;
  assign profile_timeout = emu_done_q;

endmodule // cecr_top

// ==== design/cecr_pkg.sv ====
// Constants, field layouts, decodes and types for the charger emulation
// configuration register bank.
// Assumes a 250 MHz system clock and 8-bit register data.
package cecr_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CECR_CLK_PERIOD_PS = 4000;
  localparam int CECR_TICK_TIME_US = 1000;
  localparam int CECR_TICK_CYCLES = (CECR_TICK_TIME_US * 1000) / (CECR_CLK_PERIOD_PS / 1000);

  localparam int CECR_COOL_BASE_MS = 200;
  localparam int CECR_RECH_STEP_MS = 200;
  localparam int CECR_RECH_MAX_MS = 2000;
  localparam int CECR_EMU_T0_MS = 800;
  localparam int CECR_EMU_T1_MS = 1600;
  localparam int CECR_EMU_T2_MS = 6400;
  localparam int CECR_EMU_T3_MS = 12800;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] CECR_ADDR_THRESH = 8'h1e;
  localparam logic [7:0] CECR_ADDR_TIMERS = 8'h1f;
  localparam logic [7:0] CECR_ADDR_STD_EN = 8'h20;
  localparam logic [7:0] CECR_ADDR_LEG_EN = 8'h21;
  localparam logic [7:0] CECR_ADDR_STD_TO = 8'h22;
  localparam logic [7:0] CECR_ADDR_LEG_TO1 = 8'h23;
  localparam logic [7:0] CECR_ADDR_LEG_TO2 = 8'h24;

  // ----------------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------------
  localparam logic [7:0] CECR_RST_THRESH = 8'h01;
  localparam logic [7:0] CECR_RST_TIMERS = 8'h03;
  localparam logic [7:0] CECR_RST_STD_EN = 8'h06;
  localparam logic [7:0] CECR_RST_LEG_EN = 8'h00;
  localparam logic [7:0] CECR_RST_STD_TO = 8'h10;
  localparam logic [7:0] CECR_RST_LEG_TO1 = 8'hb0;
  localparam logic [7:0] CECR_RST_LEG_TO2 = 8'h04;

  localparam logic [7:0] CECR_MASK_THRESH = 8'h0f;
  localparam logic [7:0] CECR_MASK_TIMERS = 8'h1f;
  localparam logic [7:0] CECR_MASK_STD_EN = 8'h10;
  localparam logic [7:0] CECR_FIXED_STD_EN = 8'h06;
  localparam logic [7:0] CECR_MASK_LEG_EN = 8'h7f;
  localparam logic [7:0] CECR_MASK_STD_TO = 8'h30;
  localparam logic [7:0] CECR_MASK_LEG_TO1 = 8'hff;
  localparam logic [7:0] CECR_MASK_LEG_TO2 = 8'h3f;
  localparam logic [7:0] CECR_READ_NONE = 8'h00;

  // Recharge codes above this one exceed 800 ms
  localparam logic [2:0] CECR_RECH_SEL_800 = 3'h3;
  localparam logic [2:0] CECR_RECH_SEL_MAX = 3'h7;
  localparam logic [2:0] CECR_PROFILE_DEDICATED = 3'h0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] thresh;
    logic [1:0] cool_sel;
    logic [2:0] rech_sel;
    logic ded_dis;
    logic [6:0] leg_dis;
    logic [1:0] ded_to;
    logic [6:0][1:0] leg_to;
  } cecr_cfg_t;

  typedef enum logic [1:0] {
    CECR_ATT_IDLE = 2'b00,
    CECR_ATT_REMOVE = 2'b01,
    CECR_ATT_REATTACH = 2'b10
  } cecr_att_t;

  // ----------------------------------------------------------------------
  // Decodes
  // ----------------------------------------------------------------------
  function automatic logic [15:0] cecr_cool_ms(input logic [1:0] sel);
    cecr_cool_ms = 16'(CECR_COOL_BASE_MS << sel);
  endfunction

  function automatic logic [15:0] cecr_rech_ms(input logic [2:0] sel);
    if (sel == CECR_RECH_SEL_MAX) begin
      cecr_rech_ms = 16'(CECR_RECH_MAX_MS);
    end else begin
      cecr_rech_ms = 16'(CECR_RECH_STEP_MS * (int'(sel) + 1));
    end
  endfunction

  function automatic logic [15:0] cecr_emu_ms(input logic [1:0] code);
    unique case (code)
      2'h0: cecr_emu_ms = 16'(CECR_EMU_T0_MS);
      2'h1: cecr_emu_ms = 16'(CECR_EMU_T1_MS);
      2'h2: cecr_emu_ms = 16'(CECR_EMU_T2_MS);
      2'h3: cecr_emu_ms = 16'(CECR_EMU_T3_MS);
    endcase
  endfunction

endpackage

// ==== design/cecr_timer.sv ====
// One-shot millisecond down-counter used for the block's delay timers.
// Assumes a shared one-cycle millisecond tick from the register bank.
`timescale 1ns/1ps
module cecr_timer
  import cecr_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic tick, // One-cycle millisecond tick
  input wire logic start, // Load and start
  input wire logic stop, // Abort without expiry
  input wire logic [15:0] load_ms, // Duration in milliseconds
  output logic running, // Timer counting
  output logic expired // One-cycle pulse at expiry
);

  logic [15:0] remain_q;
  logic running_q;
  logic expired_q;

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      remain_q <= '0;
      running_q <= 1'b0;
    end else if (start) begin
      remain_q <= load_ms;
      running_q <= 1'b1;
    end else if (stop) begin
      running_q <= 1'b0;
    end else if (running_q && tick) begin
      remain_q <= remain_q - 16'h0001;
      if (remain_q <= 16'h0001) begin
        running_q <= 1'b0;
      end
    end
  end

  // Expiry pulse, suppressed by restart or abort
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      expired_q <= 1'b0;
    end else begin
      expired_q <= running_q && tick && (remain_q <= 16'h0001) && !start && !stop;
    end
  end

  assign running = running_q;
  assign expired = expired_q;

endmodule // cecr_timer

// ==== verif/cecr_top_props.sv ====
// Concurrent checks on the register bank ports.
// Assumes it is bound to cecr_top and sees only its ports.
`timescale 1ns/1ps
module cecr_top_props (
  input wire logic mclk, // Clock
  input wire logic resetn, // Reset
  input wire logic rd_stb, // Read
  input wire logic [7:0] rdata, // Data
  input wire logic [7:0] vbus_current, // Load
  input wire logic temp_over, // Hot
  input wire logic bypass_reenabled, // Bypass
  input wire logic dedicated_mode_active, // Mode
  input wire logic global_timeout_disable, // Off
  input wire logic profile_start, // Start
  input wire logic emulation_success, // Ok
  input wire logic cooldown_active, // Cool
  input wire logic recharge_active, // Rech
  input wire logic attach_event, // Att
  input wire logic removal_event, // Rem
  input wire logic dedicated_profile_skip, // Skip
  input wire logic emulation_timing, // Timing
  input wire logic profile_timeout // Expiry
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  chk_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 8'h00)
    else $error("rdata not idle");
  chk_success_low: assert property ($past(vbus_current) == 8'h00 |-> !emulation_success)
    else $error("success at zero current");
  chk_success_high: assert property ($past(resetn) && $past(vbus_current) > 8'h0f
    |-> emulation_success)
    else $error("success missing");
  chk_skip_mode: assert property ($past(dedicated_mode_active) |-> !dedicated_profile_skip)
    else $error("skip in dedicated mode");
  chk_timeout_off: assert property (global_timeout_disable [*3]
    |-> !emulation_timing && !profile_timeout)
    else $error("timeout while disabled");
  chk_cool_start: assert property ($rose(temp_over) |-> ##[1:3] cooldown_active)
    else $error("cool-down not started");
  chk_rech_start: assert property (bypass_reenabled |-> ##[1:3] recharge_active)
    else $error("recharge not started");
  chk_attach_held: assert property (recharge_active |-> !attach_event)
    else $error("attach during recharge");
  chk_removal_pair: assert property (removal_event |=> attach_event)
    else $error("no attach after removal");
  chk_prof_start: assert property (profile_start && !global_timeout_disable
    |-> ##[1:3] emulation_timing)
    else $error("profile timer not started");
endmodule // cecr_top_props
bind cecr_top cecr_top_props cecr_top_props_inst (.mclk, .resetn, .rd_stb, .rdata,
  .vbus_current, .temp_over, .bypass_reenabled, .dedicated_mode_active,
  .global_timeout_disable, .profile_start, .emulation_success, .cooldown_active,
  .recharge_active, .attach_event, .removal_event, .dedicated_profile_skip,
  .emulation_timing, .profile_timeout);

// ==== verif/cecr_portable_dev.sv ====
// Portable device on the USB side: plugs in and draws a set current.
// Assumes the bench moves plug and draw just after clock edges.
`timescale 1ns/1ps
module cecr_portable_dev (
  input wire logic mclk, // Clock
  input wire logic plug, // Plugged in
  input wire logic [7:0] draw, // Load code
  output logic [7:0] vbus_current, // Sensed load
  output logic device_present, // Present
  output logic attach_detect // Attach level
);
  initial begin
    vbus_current = 8'h00;
    device_present = 1'b0;
    attach_detect = 1'b0;
  end
  // No load is seen while unplugged
  always @(posedge mclk) begin
    device_present <= plug;
    attach_detect <= plug;
    vbus_current <= plug ? draw : 8'h00;
  end
endmodule // cecr_portable_dev

// ==== verif/cecr_top_tb_top.sv ====
// Self-checking bench for the charger emulation register bank.
// Assumes a four-cycle millisecond tick so the timers run quickly.
`timescale 1ns/1ps
module cecr_top_tb_top;
  localparam int T = 4;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic sleep_active = 1'b0;
  logic temp_over = 1'b0;
  logic bypass_reenabled = 1'b0;
  logic power_switch_enable = 1'b0;
  logic dedicated_mode_active = 1'b0;
  logic global_timeout_disable = 1'b0;
  logic profile_start = 1'b0;
  logic [2:0] profile_index = 3'h0;
  logic plug = 1'b0;
  logic [7:0] draw = 8'h00;
  logic [7:0] rdata, vbus_current;
  logic device_present, attach_detect, emulation_success, cooldown_active;
  logic recharge_active, attach_event, removal_event, dedicated_profile_skip;
  logic emulation_timing, profile_timeout;
  logic [6:0] legacy_profile_enable;
  int error_cnt = 0;
  int n_tests = 0;
  int rm, at, pt;
  always #2 mclk = ~mclk;
  cecr_top #(.TICK_CYCLES(T)) cecr_top_inst (.mclk, .resetn, .addr, .wdata, .wr_stb,
    .rd_stb, .rdata, .sleep_active, .vbus_current, .temp_over, .bypass_reenabled,
    .device_present, .power_switch_enable, .attach_detect, .dedicated_mode_active,
    .global_timeout_disable, .profile_start, .profile_index, .emulation_success,
    .cooldown_active, .recharge_active, .attach_event, .removal_event,
    .dedicated_profile_skip, .legacy_profile_enable, .emulation_timing, .profile_timeout);
  cecr_portable_dev cecr_portable_dev_inst (.mclk, .plug, .draw, .vbus_current,
    .device_present, .attach_detect);
  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  function automatic logic act(input int s);
    return s == 0 ? cooldown_active : s == 1 ? recharge_active : emulation_timing;
  endfunction
  // Times one timer run, counting removal and attach pulses
  task automatic run(input int s, input int ms, input bit mid);
    int n = 0;
    int k = 0;
    rm = 0;
    at = 0;
    pt = 0;
    while (act(s) !== 1'b1 && k < 6) begin
      @(posedge mclk);
      #1 k++;
    end
    while (act(s) === 1'b1 && n < ms * T + 9) begin
      @(posedge mclk);
      #1 n++;
      if (mid && n == 9) plug <= 1'b1;
      rm += int'(removal_event === 1'b1);
      at += int'(attach_event === 1'b1);
      pt += int'(profile_timeout === 1'b1);
    end
    if (k == 6 || n == ms * T + 9) begin
      error_cnt++;
      $display("[FAIL] %0t timer wait ran out", $time);
      test_done();
    end
    repeat (6) begin
      @(posedge mclk);
      #1 rm += int'(removal_event === 1'b1);
      at += int'(attach_event === 1'b1);
      pt += int'(profile_timeout === 1'b1);
    end
    chk(8'(n >= (ms - 1) * T && n <= ms * T + 2), 8'h01);
  endtask
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] rv [7] = '{8'h01, 8'h03, 8'h06, 8'h00, 8'h10, 8'hb0, 8'h04};
    logic [7:0] wv [7] = '{8'hff, 8'hff, 8'h16, 8'hff, 8'h3c, 8'hff, 8'hff};
    logic [7:0] ev [7] = '{8'h0f, 8'h1f, 8'h16, 8'h7f, 8'h30, 8'hff, 8'h3f};
    chk({1'b0, legacy_profile_enable}, 8'h7f);
    for (int i = 0; i < 7; i++) rc(8'h1e + 8'(i), rv[i]);
    for (int i = 0; i < 7; i++) wr(8'h1e + 8'(i), wv[i]);
    for (int i = 0; i < 7; i++) rc(8'h1e + 8'(i), ev[i]);
    wr(8'h25, 8'hff);
    rc(8'h25, 8'h00);
    wr(8'h21, 8'h05);
    @(posedge mclk);
    #1 chk({1'b0, legacy_profile_enable}, 8'h7a);
    @(posedge mclk);
    sleep_active <= 1'b1;
    wr(8'h1e, 8'h0f);
    rc(8'h1e, 8'h01);
    ev[3] = 8'h05;
    for (int i = 1; i < 7; i++) rc(8'h1e + 8'(i), ev[i]);
    @(posedge mclk);
    sleep_active <= 1'b0;
    rc(8'h1e, 8'h01);
    $display("register test done");
  endtask
  task automatic t_levels();
    wr(8'h1e, 8'h03);
    plug <= 1'b1;
    for (int i = 3; i < 6; i++) begin
      draw <= 8'(i * 12 - 33);
      repeat (4) @(posedge mclk);
      #1 chk(8'(emulation_success), 8'(i > 3));
    end
    chk(8'(dedicated_profile_skip), 8'h01);
    dedicated_mode_active <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 chk(8'(dedicated_profile_skip), 8'h00);
    @(posedge mclk);
    plug <= 1'b0;
    dedicated_mode_active <= 1'b0;
    wr(8'h20, 8'h06);
    @(posedge mclk);
    #1 chk(8'(dedicated_profile_skip), 8'h00);
    $display("level test done");
  endtask
  task automatic t_timers();
    for (int c = 0; c < 4; c++) begin
      wr(8'h1f, 8'(c << 3));
      temp_over <= 1'b1;
      run(0, 200 << c, 1'b0);
      temp_over <= 1'b0;
    end
    for (int c = 0; c < 8; c++) begin
      wr(8'h1f, 8'(c));
      bypass_reenabled <= 1'b1;
      @(posedge mclk);
      bypass_reenabled <= 1'b0;
      run(1, c == 7 ? 2000 : 200 * (c + 1), c == 3);
      chk(8'(rm), 8'(c > 3));
      chk(8'(at), 8'(c >= 3));
    end
    $display("timer test done");
  endtask
  task automatic t_profiles();
    wr(8'h23, 8'h00);
    wr(8'h24, 8'h10);
    wr(8'h22, 8'h10);
    for (int p = 0; p < 8; p++) begin
      profile_index <= 3'(p);
      profile_start <= 1'b1;
      @(posedge mclk);
      profile_start <= 1'b0;
      run(2, p == 0 || p == 5 ? 1600 : 800, 1'b0);
      chk(8'(pt), 8'h01);
    end
    profile_start <= 1'b1;
    @(posedge mclk);
    profile_start <= 1'b0;
    repeat (20) @(posedge mclk);
    global_timeout_disable <= 1'b1;
    repeat (4) @(posedge mclk);
    profile_start <= 1'b1;
    @(posedge mclk);
    profile_start <= 1'b0;
    repeat (5) @(posedge mclk);
    #1 chk(8'(emulation_timing), 8'h00);
    $display("profile test done");
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    @(posedge mclk);
    t_regs();
    t_levels();
    t_timers();
    t_profiles();
    test_done();
  end
endmodule // cecr_top_tb_top
